// [core/rsp_pkg.sv]
`default_nettype none
package rsp_pkg;
   // ------------------------------------------------------------
   // sector guard byte layout
   // ------------------------------------------------------------
   localparam int RSP_SECTORS = 64;
   localparam int RSP_GB_W = 5;
   localparam int RSP_GB_LOCK_BIT = 0;
   localparam int RSP_GB_PROT_LSB = 1;
   localparam int RSP_GB_SEL_LSB = 3;
   localparam logic [4:0] RSP_GB_RESET = 5'h00;
   localparam logic [2:0] RSP_GB_RSVD_VAL = 3'h0;
   localparam logic [31:0] RSP_PWD_RESET = 32'h00000000;
   localparam int RSP_PWD_COUNT = 3;

   // ------------------------------------------------------------
   // protection and selector codes
   // ------------------------------------------------------------
   localparam logic [1:0] RSP_PROT_RD = 2'h0;
   localparam logic [1:0] RSP_PROT_RW = 2'h1;
   localparam logic [1:0] RSP_PROT_PWONLY = 2'h2;
   localparam logic [1:0] RSP_PROT_PRES_RD = 2'h3;
   localparam logic [1:0] RSP_SEL_NONE = 2'h0;

   // ------------------------------------------------------------
   // command answers
   // ------------------------------------------------------------
   localparam logic [1:0] RSP_ERR_NONE = 2'h0;
   localparam logic [1:0] RSP_ERR_LOCKED = 2'h1;
   localparam logic [1:0] RSP_ERR_DENIED = 2'h2;
   localparam logic [1:0] RSP_ERR_BUSY = 2'h3;

   typedef enum logic [1:0] {
      RSP_OP_PWD_WRITE,
      RSP_OP_LOCK,
      RSP_OP_PRESENT,
      RSP_OP_NOP
   } rsp_op_t;

   typedef enum logic {
      RSP_WR_IDLE,
      RSP_WR_BUSY
   } rsp_wr_state_t;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int RSP_CLK_PERIOD_PS = 5000;
   localparam int RSP_RF_WRITE_TIME_NS = 5750000;
   // product taken as longint, the ps figure would overflow a 32-bit int
   localparam int RSP_RF_WRITE_CYCLES =
      int'((longint'(RSP_RF_WRITE_TIME_NS) * 1000) / RSP_CLK_PERIOD_PS);

   // ------------------------------------------------------------
   // guard byte area byte offsets, four sectors per word
   // ------------------------------------------------------------
   localparam int RSP_WORD_BYTES = 4;
   localparam logic [5:0] SECTOR_SECURITY_WORD_00 = 6'h00;
   localparam logic [5:0] SECTOR_SECURITY_WORD_01 = 6'h04;
   localparam logic [5:0] SECTOR_SECURITY_WORD_02 = 6'h08;
   localparam logic [5:0] SECTOR_SECURITY_WORD_03 = 6'h0C;
   localparam logic [5:0] SECTOR_SECURITY_WORD_04 = 6'h10;
   localparam logic [5:0] SECTOR_SECURITY_WORD_05 = 6'h14;
   localparam logic [5:0] SECTOR_SECURITY_WORD_06 = 6'h18;
   localparam logic [5:0] SECTOR_SECURITY_WORD_07 = 6'h1C;
   localparam logic [5:0] SECTOR_SECURITY_WORD_08 = 6'h20;
   localparam logic [5:0] SECTOR_SECURITY_WORD_09 = 6'h24;
   localparam logic [5:0] SECTOR_SECURITY_WORD_10 = 6'h28;
   localparam logic [5:0] SECTOR_SECURITY_WORD_11 = 6'h2C;
   localparam logic [5:0] SECTOR_SECURITY_WORD_12 = 6'h30;
   localparam logic [5:0] SECTOR_SECURITY_WORD_13 = 6'h34;
   localparam logic [5:0] SECTOR_SECURITY_WORD_14 = 6'h38;
   localparam logic [5:0] SECTOR_SECURITY_WORD_15 = 6'h3C;
endpackage
`default_nettype wire

// [core/rsp_guard_store.sv]
`default_nettype none
module rsp_guard_store
   import rsp_pkg::*;
#(
   parameter int SECTORS = RSP_SECTORS,
   parameter int IDX_W = $clog2(RSP_SECTORS)
)
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic rf_we_i,
   input wire logic [IDX_W-1:0] rf_idx_i,
   input wire logic [RSP_GB_W-1:0] rf_data_i,
   input wire logic host_we_i,
   input wire logic [IDX_W-1:0] host_idx_i,
   input wire logic [RSP_GB_W-1:0] host_data_i,
   output logic [SECTORS*RSP_GB_W-1:0] all_o
);
   // ------------------------------------------------------------
   // guard byte storage
   // ------------------------------------------------------------
   logic [RSP_GB_W-1:0] gb_reg [SECTORS];

   // host write lands last, so it wins a same-sector collision
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         for (int i = 0; i < SECTORS; i++)
         begin
            gb_reg[i] <= RSP_GB_RESET;
         end
      end
      else
      begin
         if (rf_we_i)
         begin
            gb_reg[rf_idx_i] <= rf_data_i;
         end
         if (host_we_i)
         begin
            gb_reg[host_idx_i] <= host_data_i;
         end
      end
   end

   always_comb
   begin
      for (int i = 0; i < SECTORS; i++)
      begin
         all_o[i*RSP_GB_W +: RSP_GB_W] = gb_reg[i];
      end
   end
endmodule
`default_nettype wire

// [core/rsp_access_ctrl.sv]
// How it works
// - one guard byte per sector: lock bit0, protection 2:1, selector 4:3, 7:5 zero
// - every guard byte resets to zero
// - byte n of area is sector n, low sector in bits 7:0
// - unlocked sector: read and write allowed from rf side
// - locked, not presented: 00 read, 01 read+write, 10/11 nothing
// - locked, presented: 00/01/10 read+write, 11 read only
// - selector 00 no password, 01..11 password 1..3
// - three 32-bit passwords in slots 1, 2, 3
// - password write stores value after the write cycle finishes
// - password write accepted only when that password is presented
// - all passwords reset to zero and active
// - lock command writes bits 4:1, sets bit 0, takes effect at once
// - lock on already locked sector fails with error code
// - correct presentation grants rights to linked sectors until next one
// - wrong presentation revokes all granted rights
// - reset starts with no password presented
// - guard byte returned with rf read answer when option flag set
// - host may read the guard byte area only with the upper select bit set
// - host writes guard bytes only with host password presented
// - host write to a guard byte drops that sector's presented rights
`default_nettype none
module rsp_access_ctrl
   import rsp_pkg::*;
#(
   parameter int SECTORS = RSP_SECTORS,
   parameter int WRITE_CYCLES = RSP_RF_WRITE_CYCLES
)
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic rf_cmd_valid_i,
   input wire logic [1:0] rf_cmd_op_i,
   input wire logic [5:0] rf_cmd_sector_i,
   input wire logic [1:0] rf_cmd_pwd_num_i,
   input wire logic [31:0] rf_cmd_data_i,
   output logic rf_cmd_done_o,
   output logic [1:0] rf_cmd_err_o,
   output logic rf_busy_o,
   input wire logic rf_acc_valid_i,
   input wire logic [5:0] rf_acc_sector_i,
   input wire logic rf_acc_option_i,
   output logic rf_acc_done_o,
   output logic rf_rd_ok_o,
   output logic rf_wr_ok_o,
   output logic rf_guard_valid_o,
   output logic [7:0] rf_guard_byte_o,
   input wire logic host_req_i,
   input wire logic host_we_i,
   input wire logic host_upper_select_bit_i,
   input wire logic [5:0] host_addr_i,
   input wire logic [7:0] host_wdata_i,
   input wire logic host_pwd_ok_i,
   output logic host_ack_o,
   output logic host_err_o,
   output logic [7:0] host_rdata_o
);
   localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(WRITE_CYCLES - 1);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [RSP_GB_W-1:0] gb_of(input logic [SECTORS*RSP_GB_W-1:0] all,
                                                 input logic [5:0] idx);
      gb_of = all[idx*RSP_GB_W +: RSP_GB_W];
   endfunction
   // returns {read_ok, write_ok}
   function automatic logic [1:0] rights(input logic [RSP_GB_W-1:0] gb, input logic granted);
      logic [1:0] prot;
      prot = gb[RSP_GB_PROT_LSB +: 2];
      if (!gb[RSP_GB_LOCK_BIT])
      begin
         rights = 2'h3;
      end
      else if (granted)
      begin
         rights = (prot == RSP_PROT_PRES_RD) ? 2'h2 : 2'h3;
      end
      else
      begin
         rights = {prot == RSP_PROT_RD || prot == RSP_PROT_RW, prot == RSP_PROT_RW};
      end
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [SECTORS*RSP_GB_W-1:0] gb_all;
   logic [1:0] pres_reg, pend_num_reg;
   logic [SECTORS-1:0] reinit_reg;
   logic [31:0] pwd_reg [1:RSP_PWD_COUNT];
   rsp_wr_state_t wr_state_reg;
   logic [CNT_W-1:0] wr_cnt_reg;
   logic [31:0] pend_val_reg;
   logic [RSP_GB_W-1:0] cmd_gb;
   logic rf_take, pwd_num_ok, do_present, pres_match, do_lock, do_pwd_write, wr_commit;
   logic host_ok, host_wr;

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   assign rf_take = rf_cmd_valid_i && (wr_state_reg == RSP_WR_IDLE);
   assign cmd_gb = gb_of(gb_all, rf_cmd_sector_i);
   assign pwd_num_ok = (rf_cmd_pwd_num_i != RSP_SEL_NONE);
   assign pres_match = (rf_cmd_data_i == pwd_reg[rf_cmd_pwd_num_i]);
   assign do_present = rf_take && (rf_cmd_op_i == RSP_OP_PRESENT) && pwd_num_ok;
   assign do_lock = rf_take && (rf_cmd_op_i == RSP_OP_LOCK)
                    && !cmd_gb[RSP_GB_LOCK_BIT];
   assign do_pwd_write = rf_take && (rf_cmd_op_i == RSP_OP_PWD_WRITE) && pwd_num_ok
                         && (pres_reg == rf_cmd_pwd_num_i);
   assign wr_commit = (wr_state_reg == RSP_WR_BUSY) && (wr_cnt_reg == '0);
   assign host_ok = host_req_i && host_upper_select_bit_i;
   assign host_wr = host_ok && host_we_i && host_pwd_ok_i;

   rsp_guard_store #(
      .SECTORS(SECTORS),
      .IDX_W(6)
   ) u_store (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .rf_we_i(do_lock),
      .rf_idx_i(rf_cmd_sector_i),
      .rf_data_i({rf_cmd_data_i[4:1], 1'b1}),
      .host_we_i(host_wr),
      .host_idx_i(host_addr_i),
      .host_data_i(host_wdata_i[RSP_GB_W-1:0]),
      .all_o(gb_all)
   );

   // ------------------------------------------------------------
   // presented password
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         pres_reg <= RSP_SEL_NONE;
      end
      else if (do_present)
      begin
         pres_reg <= pres_match ? rf_cmd_pwd_num_i : RSP_SEL_NONE;
      end
   end
   // host write sets the drop bit even if a presentation clears it now
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         reinit_reg <= '0;
      end
      else
      begin
         reinit_reg <= do_present ? '0 : reinit_reg;
         if (host_wr)
         begin
            reinit_reg[host_addr_i] <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // password write cycle
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         wr_state_reg <= RSP_WR_IDLE;
         wr_cnt_reg <= '0;
         pend_num_reg <= RSP_SEL_NONE;
         pend_val_reg <= RSP_PWD_RESET;
      end
      else
      begin
         unique case (wr_state_reg)
            RSP_WR_IDLE:
            begin
               if (do_pwd_write)
               begin
                  wr_state_reg <= RSP_WR_BUSY;
                  wr_cnt_reg <= CNT_LOAD;
                  pend_num_reg <= rf_cmd_pwd_num_i;
                  pend_val_reg <= rf_cmd_data_i;
               end
            end
            RSP_WR_BUSY:
            begin
               if (wr_cnt_reg == '0)
               begin
                  wr_state_reg <= RSP_WR_IDLE;
               end
               else
               begin
                  wr_cnt_reg <= wr_cnt_reg - 1'b1;
               end
            end
         endcase
      end
   end
   // new value only becomes live once the cycle ends
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         for (int i = 1; i <= RSP_PWD_COUNT; i++)
         begin
            pwd_reg[i] <= RSP_PWD_RESET;
         end
      end
      else if (wr_commit)
      begin
         pwd_reg[pend_num_reg] <= pend_val_reg;
      end
   end

   // ------------------------------------------------------------
   // rf command answer
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         rf_cmd_done_o <= 1'b0;
         rf_cmd_err_o <= RSP_ERR_NONE;
         rf_busy_o <= 1'b0;
      end
      else
      begin
         rf_busy_o <= do_pwd_write || (wr_state_reg == RSP_WR_BUSY && !wr_commit);
         rf_cmd_done_o <= wr_commit || (rf_cmd_valid_i && !do_pwd_write);
         if (wr_commit)
         begin
            rf_cmd_err_o <= RSP_ERR_NONE;
         end
         else if (rf_cmd_valid_i && !rf_take)
         begin
            rf_cmd_err_o <= RSP_ERR_BUSY;
         end
         else if (rf_cmd_valid_i && rf_cmd_op_i == RSP_OP_LOCK && !do_lock)
         begin
            rf_cmd_err_o <= RSP_ERR_LOCKED;
         end
         else if (rf_cmd_valid_i && rf_cmd_op_i != RSP_OP_LOCK && !do_present
                  && !do_pwd_write && rf_cmd_op_i != RSP_OP_NOP)
         begin
            rf_cmd_err_o <= RSP_ERR_DENIED;
         end
         else
         begin
            rf_cmd_err_o <= RSP_ERR_NONE;
         end
      end
   end

   // ------------------------------------------------------------
   // rf access query
   // ------------------------------------------------------------
   logic [RSP_GB_W-1:0] acc_gb, acc_gb_reg;
   logic acc_grant, acc_grant_reg;
   logic [1:0] acc_rights;
   assign acc_gb = gb_of(gb_all, rf_acc_sector_i);
   // selector 00 can never match a presented slot
   assign acc_grant = (acc_gb[RSP_GB_SEL_LSB +: 2] != RSP_SEL_NONE)
                      && (acc_gb[RSP_GB_SEL_LSB +: 2] == pres_reg)
                      && !reinit_reg[rf_acc_sector_i];
   assign acc_rights = rights(acc_gb, acc_grant);
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         rf_acc_done_o <= 1'b0;
         rf_rd_ok_o <= 1'b0;
         rf_wr_ok_o <= 1'b0;
         rf_guard_valid_o <= 1'b0;
         rf_guard_byte_o <= 8'h00;
         acc_gb_reg <= RSP_GB_RESET;
         acc_grant_reg <= 1'b0;
      end
      else
      begin
         rf_acc_done_o <= rf_acc_valid_i;
         rf_rd_ok_o <= rf_acc_valid_i && acc_rights[1];
         rf_wr_ok_o <= rf_acc_valid_i && acc_rights[0];
         rf_guard_valid_o <= rf_acc_valid_i && rf_acc_option_i;
         rf_guard_byte_o <= (rf_acc_valid_i && rf_acc_option_i)
                            ? {RSP_GB_RSVD_VAL, acc_gb} : 8'h00;
         acc_gb_reg <= acc_gb;
         acc_grant_reg <= acc_grant;
      end
   end

   // ------------------------------------------------------------
   // host guard byte access
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (!resetn_i)
      begin
         host_ack_o <= 1'b0;
         host_err_o <= 1'b0;
         host_rdata_o <= 8'h00;
      end
      else
      begin
         host_ack_o <= host_req_i;
         host_err_o <= host_req_i && (!host_upper_select_bit_i
                                      || (host_we_i && !host_pwd_ok_i));
         host_rdata_o <= (host_ok && !host_we_i)
                         ? {RSP_GB_RSVD_VAL, gb_of(gb_all, host_addr_i)} : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);
   a_rsvd_bits_zero: assert property (
      rf_guard_byte_o[7:5] == 3'h0 && host_rdata_o[7:5] == 3'h0)
      else $error("reserved guard bits not zero");
   a_unlocked_full: assert property (
      rf_acc_done_o && !acc_gb_reg[RSP_GB_LOCK_BIT] |-> rf_rd_ok_o && rf_wr_ok_o)
      else $error("unlocked sector not fully open");
   a_nopres_rights: assert property (
      rf_acc_done_o && acc_gb_reg[RSP_GB_LOCK_BIT] && !acc_grant_reg
      |-> rf_rd_ok_o == !acc_gb_reg[2]
          && rf_wr_ok_o == (acc_gb_reg[2:1] == RSP_PROT_RW))
      else $error("non-presented rights wrong");
   a_pres_rights: assert property (
      rf_acc_done_o && acc_gb_reg[RSP_GB_LOCK_BIT] && acc_grant_reg
      |-> rf_rd_ok_o && rf_wr_ok_o == (acc_gb_reg[2:1] != RSP_PROT_PRES_RD))
      else $error("presented rights wrong");
   a_pwd_commit: assert property (
      wr_commit |=> pwd_reg[$past(pend_num_reg)] == $past(pend_val_reg) && rf_cmd_done_o)
      else $error("password not stored at end of write");
   a_pwd_needs_pres: assert property (
      rf_take && rf_cmd_op_i == RSP_OP_PWD_WRITE && pres_reg != rf_cmd_pwd_num_i
      |=> rf_cmd_done_o && rf_cmd_err_o == RSP_ERR_DENIED && !rf_busy_o)
      else $error("password write taken without presentation");
   a_lock_sets: assert property (
      do_lock && !(host_wr && host_addr_i == rf_cmd_sector_i)
      |=> gb_of(gb_all, $past(rf_cmd_sector_i)) == {$past(rf_cmd_data_i[4:1]), 1'b1})
      else $error("lock did not write guard byte");
   a_lock_reject: assert property (
      rf_take && rf_cmd_op_i == RSP_OP_LOCK && cmd_gb[RSP_GB_LOCK_BIT]
      && !(host_wr && host_addr_i == rf_cmd_sector_i)
      |=> rf_cmd_err_o == RSP_ERR_LOCKED
          ##0 gb_of(gb_all, $past(rf_cmd_sector_i)) == $past(cmd_gb))
      else $error("locked sector relocked");
   a_bad_pres_revoke: assert property (
      do_present && !pres_match |=> pres_reg == RSP_SEL_NONE)
      else $error("wrong password kept rights");
   a_host_wr_gate: assert property (
      host_req_i && host_we_i && !host_pwd_ok_i |=> host_ack_o && host_err_o)
      else $error("host write without password accepted");
   a_host_reinit: assert property (
      host_wr |=> reinit_reg[$past(host_addr_i)])
      else $error("host write kept presented rights");
   c_present_ok: cover property (do_present && pres_match);
   c_pwd_written: cover property (wr_commit);
   c_lock_refused: cover property (rf_cmd_done_o && rf_cmd_err_o == RSP_ERR_LOCKED);
   c_pres_grant: cover property (rf_acc_done_o && acc_grant_reg);
endmodule
`default_nettype wire

// [test/rsp_host_model.sv]
`default_nettype none
// ------------------------------------------------------------
// two-wire host password state
// ------------------------------------------------------------
module rsp_host_model
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic present_i,
   input wire logic good_i,
   output logic pwd_ok_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // a wrong value withdraws the right, as on the real host side
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         pwd_ok_o <= 1'b0;
      else if (present_i)
         pwd_ok_o <= good_i;
   end
endmodule
`default_nettype wire

// [test/rf_sector_password_access_control_tb_top.sv]
`default_nettype none
module rf_sector_password_access_control_tb_top
   import rsp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic rf_cmd_valid_i = 1'b0;
   logic [1:0] rf_cmd_op_i = 2'h3;
   logic [5:0] rf_cmd_sector_i = 6'h00;
   logic [1:0] rf_cmd_pwd_num_i = 2'h0;
   logic [31:0] rf_cmd_data_i = 32'h0;
   logic rf_acc_valid_i = 1'b0;
   logic [5:0] rf_acc_sector_i = 6'h00;
   logic rf_acc_option_i = 1'b0;
   logic host_req_i = 1'b0;
   logic host_we_i = 1'b0;
   logic host_upper_select_bit_i = 1'b0;
   logic [5:0] host_addr_i = 6'h00;
   logic [7:0] host_wdata_i = 8'h00;
   logic hm_present = 1'b0;
   logic hm_good = 1'b0;
   logic host_pwd_ok_i;
   logic rf_cmd_done_o, rf_busy_o, rf_acc_done_o, rf_rd_ok_o, rf_wr_ok_o, rf_guard_valid_o;
   logic host_ack_o, host_err_o;
   logic [1:0] rf_cmd_err_o;
   logic [7:0] rf_guard_byte_o, host_rdata_o;
   int fails = 0;
   int checks = 0;
   int i;
   // lock bits 4:1 and expected rights, not presented and presented
   logic [3:0] lk [6] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h3};
   logic [1:0] np [6] = '{2'h2, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0};
   logic [1:0] pr [6] = '{2'h2, 2'h3, 2'h3, 2'h3, 2'h2, 2'h0};

   always #2.5 clk_sys_i = ~clk_sys_i;

   rsp_access_ctrl #(.SECTORS(64), .WRITE_CYCLES(8)) i_rsp_access_ctrl (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .rf_cmd_valid_i(rf_cmd_valid_i),
      .rf_cmd_op_i(rf_cmd_op_i), .rf_cmd_sector_i(rf_cmd_sector_i),
      .rf_cmd_pwd_num_i(rf_cmd_pwd_num_i), .rf_cmd_data_i(rf_cmd_data_i),
      .rf_cmd_done_o(rf_cmd_done_o), .rf_cmd_err_o(rf_cmd_err_o), .rf_busy_o(rf_busy_o),
      .rf_acc_valid_i(rf_acc_valid_i), .rf_acc_sector_i(rf_acc_sector_i),
      .rf_acc_option_i(rf_acc_option_i), .rf_acc_done_o(rf_acc_done_o),
      .rf_rd_ok_o(rf_rd_ok_o), .rf_wr_ok_o(rf_wr_ok_o), .rf_guard_valid_o(rf_guard_valid_o),
      .rf_guard_byte_o(rf_guard_byte_o), .host_req_i(host_req_i), .host_we_i(host_we_i),
      .host_upper_select_bit_i(host_upper_select_bit_i), .host_addr_i(host_addr_i),
      .host_wdata_i(host_wdata_i), .host_pwd_ok_i(host_pwd_ok_i), .host_ack_o(host_ack_o),
      .host_err_o(host_err_o), .host_rdata_o(host_rdata_o));

   rsp_host_model i_rsp_host_model (.clk_i(clk_sys_i), .resetn_i(resetn_i),
      .present_i(hm_present), .good_i(hm_good), .pwd_ok_o(host_pwd_ok_i));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_done(input logic [1:0] err);
      int n;
      n = 0;
      #1;
      // bounded so a lost answer cannot hang the run
      while (rf_cmd_done_o !== 1'b1 && n < 20)
      begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      chk({7'h00, rf_cmd_done_o}, 8'h01);
      chk({6'h00, rf_cmd_err_o}, {6'h00, err});
   endtask

   task automatic cmd(input logic [1:0] op, input logic [5:0] sec, input logic [1:0] num,
                      input logic [31:0] d, input logic [1:0] err, input logic wt);
      @(posedge clk_sys_i);
      rf_cmd_valid_i <= 1'b1;
      rf_cmd_op_i <= op;
      rf_cmd_sector_i <= sec;
      rf_cmd_pwd_num_i <= num;
      rf_cmd_data_i <= d;
      @(posedge clk_sys_i);
      rf_cmd_valid_i <= 1'b0;
      if (wt)
         wait_done(err);
   endtask

   task automatic acc(input logic [5:0] sec, input logic opt, input logic [1:0] rw,
                      input logic [7:0] g);
      @(posedge clk_sys_i);
      rf_acc_valid_i <= 1'b1;
      rf_acc_sector_i <= sec;
      rf_acc_option_i <= opt;
      @(posedge clk_sys_i);
      rf_acc_valid_i <= 1'b0;
      #1;
      chk({6'h00, rf_acc_done_o, rf_guard_valid_o}, {6'h00, 1'b1, opt});
      chk({6'h00, rf_rd_ok_o, rf_wr_ok_o}, {6'h00, rw});
      chk(rf_guard_byte_o, g);
   endtask

   task automatic host(input logic we, input logic ub, input logic [5:0] a,
                       input logic [7:0] wd, input logic err, input logic [7:0] rd);
      @(posedge clk_sys_i);
      host_req_i <= 1'b1;
      host_we_i <= we;
      host_upper_select_bit_i <= ub;
      host_addr_i <= a;
      host_wdata_i <= wd;
      @(posedge clk_sys_i);
      host_req_i <= 1'b0;
      #1;
      chk({6'h00, host_ack_o, host_err_o}, {6'h00, 1'b1, err});
      if (!we)
         chk(host_rdata_o, rd);
   endtask

   task automatic tend(input string nm);
      $display("test %s finished", nm);
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      for (i = 0; i < 64; i++)
         host(1'b0, 1'b1, i[5:0], 8'h00, 1'b0, 8'h00);
      acc(6'h09, 1'b1, 2'h3, 8'h00);
      acc(6'h09, 1'b0, 2'h3, 8'h00);
      host(1'b0, 1'b0, 6'h00, 8'h00, 1'b1, 8'h00);
      host(1'b1, 1'b1, 6'h00, 8'h01, 1'b1, 8'h00);
      tend("reset");
      for (i = 0; i < 6; i++)
      begin
         cmd(RSP_OP_LOCK, i[5:0], 2'h0, {27'h0, lk[i], 1'b0}, RSP_ERR_NONE, 1'b1);
         acc(i[5:0], 1'b1, np[i], {3'h0, lk[i], 1'b1});
         host(1'b0, 1'b1, i[5:0], 8'h00, 1'b0, {3'h0, lk[i], 1'b1});
      end
      cmd(RSP_OP_LOCK, 6'h01, 2'h0, 32'h1E, RSP_ERR_LOCKED, 1'b1);
      acc(6'h01, 1'b1, 2'h2, 8'h09);
      tend("lock");
      cmd(RSP_OP_PRESENT, 6'h00, 2'h1, 32'h0, RSP_ERR_NONE, 1'b1);
      for (i = 0; i < 6; i++)
         acc(i[5:0], 1'b1, pr[i], {3'h0, lk[i], 1'b1});
      cmd(RSP_OP_PWD_WRITE, 6'h00, 2'h2, 32'h0, RSP_ERR_DENIED, 1'b1);
      cmd(RSP_OP_PRESENT, 6'h00, 2'h0, 32'h0, RSP_ERR_DENIED, 1'b1);
      cmd(RSP_OP_PWD_WRITE, 6'h00, 2'h1, 32'h12345678, RSP_ERR_NONE, 1'b0);
      cmd(RSP_OP_PRESENT, 6'h00, 2'h1, 32'h0, RSP_ERR_BUSY, 1'b1);
      chk({7'h00, rf_busy_o}, 8'h01);
      @(posedge clk_sys_i);
      wait_done(RSP_ERR_NONE);
      chk({7'h00, rf_busy_o}, 8'h00);
      cmd(RSP_OP_PRESENT, 6'h00, 2'h1, 32'h0, RSP_ERR_NONE, 1'b1);
      acc(6'h01, 1'b1, 2'h2, 8'h09);
      cmd(RSP_OP_PRESENT, 6'h00, 2'h1, 32'h12345678, RSP_ERR_NONE, 1'b1);
      acc(6'h01, 1'b1, 2'h3, 8'h09);
      tend("password");
      @(posedge clk_sys_i);
      hm_present <= 1'b1;
      hm_good <= 1'b1;
      @(posedge clk_sys_i);
      hm_present <= 1'b0;
      // top bits are written as ones to prove they are dropped
      host(1'b1, 1'b1, 6'h03, 8'hED, 1'b0, 8'h00);
      host(1'b0, 1'b1, 6'h03, 8'h00, 1'b0, 8'h0D);
      acc(6'h03, 1'b1, 2'h0, 8'h0D);
      acc(6'h02, 1'b1, 2'h3, 8'h0B);
      tend("host");
      @(posedge clk_sys_i);
      resetn_i <= 1'b0;
      repeat (10) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      acc(6'h01, 1'b1, 2'h3, 8'h00);
      tend("second reset");
      stop_test;
   end

   // run needs well under a thousand cycles
   initial
   begin
      repeat (3000) @(posedge clk_sys_i);
      fails++;
      stop_test;
   end
endmodule
`default_nettype wire
